// ### rdl_mem_model.sv
/*
  shared system memory seen by the receive dma engine.
  assumes word requests held until ack; lat of 2 or more.
*/
`timescale 1ns/1ps
`default_nettype none
module rdl_mem_model import rdl_pkg::*; (
  input  wire logic         clk,       // system clock
  input  wire logic         rst,       // sync reset
  input  wire logic   [3:0] lat,       // cycles a request waits
  input  wire rdl_mem_req_t mem_req,   // request from engine
  input  wire logic         mem_valid, // request pending
  output var  logic         mem_ack,   // one-cycle done
  output var  logic  [31:0] mem_rdata  // read data with ack
);
  logic      [31:0] mem [0:511];            // words, byte address 10:2
  logic       [3:0] wait_r;                 // cycles the request has stood
  wire logic  [8:0] idx  = mem_req.addr[10:2]; // low pointer bits unused
  wire logic        fire = mem_valid && !mem_ack && wait_r == lat - 4'h1;

  initial for (int i = 0; i < 512; i++) mem[i] = 32'hffffffff;

  // the !mem_ack term skips a stale request shown just after an ack, for any lat
  always @(posedge clk) begin
    if (rst || !mem_valid || mem_ack) begin
      wait_r <= 4'h0;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
    mem_ack <= !rst && fire;
    // released data lines flip instead of holding the last word
    mem_rdata <= fire ? mem[idx] : ~mem_rdata;
    // host words and status word share one store
    if (fire && mem_req.we) begin
      for (int b = 0; b < 4; b++) begin
        if (mem_req.be[b]) mem[idx][8*b +: 8] <= mem_req.wdata[8*b +: 8];
      end
    end
  end
endmodule
`default_nettype wire

// ### rdl_pkg.sv
/*
  constants, types and the register map of the receive descriptor dma engine.
  assumes one clock, synchronous active-high reset, apb register access and a
  word-wide memory master port whose slave answers with a one-cycle ack.
*/
// Behaviour
// RULE1: one descriptor list per channel, 256 channels
// RULE2: four-word descriptor; engine writes the status word
// RULE3: section size up to 65535 in word 0
// RULE4: frame end closes descriptor; next starts packet
// RULE5: transmit byte-aligned start belongs to transmit side
// RULE6: host keeps receive pointers word aligned
// RULE7: fetch all link words on command or branch; engine fetches them only when the channel's next beat is offered
// RULE8: write status word after finishing a descriptor
// RULE9: hold clear means branch to next pointer
// RULE10: hold set means one re-read, then park
// RULE11: re-read refreshes only hold and next pointer
// RULE12: host-initiated vector after status when requested
// RULE13: first descriptor of packet starts at offset
// RULE14: host keeps four times offset below size
// RULE15: descriptor tag copied into every vector
// RULE16: host programs size as multiple of four
// RULE17: byte order follows the endian setting
// RULE18: frame status stripped, only in status word
// RULE19: host sizes sections four bytes over frame
// RULE20: abort/branch starts new list at branch address
// RULE21: full section sets complete and byte count
// RULE22: frame end sets end, complete, errors, vector
// RULE23: status word: end 31, complete 30, errors 20:16
package rdl_pkg;
  localparam int NUM_CH = 256;               // receive channels
  localparam int CH_W   = 8;                 // channel number width

  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00; // endian, transparent, vector enable
  localparam logic [7:0] OFF_BRANCH = 8'h04; // branch_descriptor_address
  localparam logic [7:0] OFF_CMD    = 8'h08; // command write / pending read
  localparam logic [7:0] OFF_STAT   = 8'h0c; // engine state

  // control register fields and reset value
  localparam int CTRL_BIG_BIT = 0;           // big-endian byte order
  localparam int CTRL_TRN_BIT = 1;           // transparent mode
  localparam int CTRL_FEV_BIT = 2;           // frame end vector enable
  localparam int CTRL_W       = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h4;

  // command register fields and opcodes
  localparam int CMD_OP_LO = 8;              // op in [9:8], channel in [7:0]
  localparam int CMD_PEND_BIT = 31;          // read: command still pending
  localparam logic [1:0] CMD_RECEIVE    = 2'h1;
  localparam logic [1:0] CMD_HOLD_RESET = 2'h2;
  localparam logic [1:0] CMD_ABORT      = 2'h3;

  // descriptor word 0 fields
  localparam int W0_HOLD = 30;
  localparam int W0_RHI  = 29;
  localparam int W0_OFS_HI = 28;
  localparam int W0_OFS_LO = 26;
  localparam int W0_TAG_HI = 21;
  localparam int W0_TAG_LO = 16;
  localparam int W0_SIZE_HI = 15;

  // byte offsets of descriptor words
  localparam logic [31:0] DW_NEXT = 32'h4;
  localparam logic [31:0] DW_DPTR = 32'h8;
  localparam logic [31:0] DW_STAT = 32'hc;
  localparam logic [31:0] PTR_MASK = 32'hfffffffc;

  // status word fields
  localparam int ST_FE_BIT = 31;
  localparam int ST_C_BIT  = 30;
  localparam int ST_ERR_LO = 16;
  localparam int ERR_W     = 5;              // max, overflow, crc, length, abort
  localparam int ERR_ABORT = 0;

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_DATA, S_STATUS, S_REPOLL} rdl_state_t;

  typedef struct packed {
    logic            we;                     // write when high
    logic [31:0]     addr;                   // byte address, word aligned
    logic [31:0]     wdata;
    logic [3:0]      be;                     // byte enables
  } rdl_mem_req_t;

  typedef struct packed {
    logic [CH_W-1:0] chan;
    logic [31:0]     data;                   // payload, or frame status when last
    logic [2:0]      nbytes;                 // valid payload bytes, 1 to 4
    logic            last;                   // beat is the frame status word
  } rdl_rx_beat_t;

  typedef struct packed {
    logic [CH_W-1:0] chan;
    logic            frame_end;              // frame end vector
    logic            host_irq;               // host-initiated vector
    logic [5:0]      tag;                    // descriptor_tag
  } rdl_vec_t;
endpackage

// ### rdl_rx_dma.sv
/*
  receive descriptor dma engine: walks per-channel descriptor lists, stores
  received words into host sections and writes status back.
  assumes the memory slave holds mem_ack for one cycle per request, and that
  only the last payload beat of a frame carries fewer than four bytes.
*/
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module rdl_rx_dma import rdl_pkg::*; (
  input  wire logic               clk,        // system clock, 50 mhz
  input  wire logic               rst,        // synchronous, active high
  input  wire logic               psel,       // apb select
  input  wire logic               penable,    // apb access phase
  input  wire logic               pwrite,     // apb direction
  input  wire logic [7:0]         paddr,      // apb byte address
  input  wire logic [31:0]        pwdata,     // apb write data
  output var  logic [31:0]        prdata,     // apb read data
  output var  logic               pready,     // apb ready
  output var  logic               pslverr,    // apb error, unmapped
  input  wire rdl_rx_beat_t       rx_beat,    // receive buffer beat
  input  wire logic               rx_valid,   // beat offered
  output var  logic               rx_ready,   // beat taken
  output var  rdl_mem_req_t       mem_req,    // memory request
  output var  logic               mem_valid,  // request pending
  input  wire logic               mem_ack,    // request done
  input  wire logic [31:0]        mem_rdata,  // read data with ack
  output var  rdl_vec_t           vec,        // interrupt vector
  output var  logic               vec_valid   // vector pulse
);

  // byte lanes of a partial word, mirrored in big-endian order
  function automatic logic [3:0] lanes(input logic [2:0] n, input logic big);
    logic [3:0] le;
    le = 4'h0;
    for (int i = 0; i < 4; i++) begin
      le[i] = (3'(i) < n);
    end
    return big ? {le[0], le[1], le[2], le[3]} : le;
  endfunction

  // byte swap for big-endian storage
  function automatic logic [31:0] order(input logic [31:0] d, input logic big);
    return big ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
  endfunction

  // register decode, used by the error answer only; the read mux decodes paddr itself
  function automatic logic mapped(input logic [7:0] a);
    return (a == OFF_CTRL) || (a == OFF_BRANCH) || (a == OFF_CMD) || (a == OFF_STAT);
  endfunction

  logic [CTRL_W-1:0] ctrl_r;                  // control bits
  logic [31:0]       branch_r;                // branch descriptor address
  logic              cmd_pend_r;              // command waiting for engine
  logic [1:0]        cmd_op_r;                // pending opcode
  logic [CH_W-1:0]   cmd_ch_r;                // pending channel
  logic              cmd_take;                // engine takes the command

  // per-channel database
  logic [31:0]       db_addr [NUM_CH];        // current descriptor address
  logic [31:0]       db_w0   [NUM_CH];        // cached word 0
  logic [31:0]       db_next [NUM_CH];        // next_descriptor_pointer
  logic [31:0]       db_dptr [NUM_CH];        // rx_section_pointer
  logic [16:0]       db_cnt  [NUM_CH];        // bytes stored so far
  logic [4:0]        db_start[NUM_CH];        // header offset in bytes
  logic [NUM_CH-1:0] db_loaded;               // descriptor cached
  logic [NUM_CH-1:0] db_held;                 // parked or never activated
  logic [NUM_CH-1:0] db_newpkt;               // next descriptor starts a packet
  logic [NUM_CH-1:0] db_mid;                  // frame partly stored

  rdl_state_t        state_r;                 // engine state
  logic [1:0]        widx_r;                  // word index of fetch or re-read
  logic [CH_W-1:0]   ch_r;                    // channel being served
  logic [16:0]       bcnt_r;                  // count of beat being written
  logic              abort_r;                 // status write ends an abort
  logic              hold_seen_r;             // hold bit seen on re-read
  logic [31:0]       rd_mux;                  // apb read value
  logic [17:0]       fill_nxt;                // start plus count after beat

  logic [CH_W-1:0]   rch;                     // offered channel
  logic              big;                     // big-endian in force
  assign rch = rx_beat.chan;
  assign big = ctrl_r[CTRL_BIG_BIT];

  // apb: zero wait states
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  // read mux
  always_comb begin
    rd_mux = 32'h0;
    case (paddr)
      OFF_CTRL:   rd_mux[CTRL_W-1:0] = ctrl_r;
      OFF_BRANCH: rd_mux = branch_r;
      OFF_CMD:    rd_mux = {cmd_pend_r, 21'h0, cmd_op_r, cmd_ch_r};
      OFF_STAT:   rd_mux = {21'h0, state_r, ch_r};
      default:    rd_mux = 32'h0;         // unmapped reads as zero
    endcase
  end

  // read data captured in the setup phase, stable through access
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  // control and branch registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r   <= CTRL_RST;
      branch_r <= 32'h0;
    end else if (psel && penable && pwrite) begin
      if (paddr == OFF_CTRL) begin
        ctrl_r <= pwdata[CTRL_W-1:0];
      end
      if (paddr == OFF_BRANCH) begin
        branch_r <= pwdata & PTR_MASK;    // [RULE6]
      end
    end
  end

  // command slot; a write while pending is dropped, even one in the cycle of the take
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_pend_r <= 1'b0;
      cmd_op_r   <= 2'h0;
      cmd_ch_r   <= '0;
    end else if (psel && penable && pwrite && paddr == OFF_CMD && !cmd_pend_r) begin
      cmd_pend_r <= (pwdata[CMD_OP_LO +: 2] != 2'h0);
      cmd_op_r   <= pwdata[CMD_OP_LO +: 2];
      cmd_ch_r   <= pwdata[CH_W-1:0];
    end else if (cmd_take) begin
      cmd_pend_r <= 1'b0;
    end
  end

  // commands and beats only start from idle; commands go first
  assign cmd_take = (state_r == S_IDLE) && cmd_pend_r;
  assign rx_ready = (state_r == S_IDLE) && !cmd_pend_r && rx_valid
                    && db_loaded[rch] && !db_held[rch];
  assign mem_valid = (state_r != S_IDLE);

  // fill level if the pending data beat lands
  assign fill_nxt = 18'(db_start[ch_r]) + 18'(db_cnt[ch_r]) + 18'(bcnt_r);

  // engine: list walking, data and status writes, channel database
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r     <= S_IDLE;
      widx_r      <= 2'h0;
      ch_r        <= '0;
      bcnt_r      <= 17'h0;
      abort_r     <= 1'b0;
      hold_seen_r <= 1'b0;
      mem_req     <= '0;
      vec         <= '0;
      vec_valid   <= 1'b0;
      db_loaded   <= '0;
      db_held     <= '1;                     // inactive until a receive or abort command
      db_newpkt   <= '1;
      db_mid      <= '0;
    end else begin
      vec_valid <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (cmd_pend_r) begin
            ch_r <= cmd_ch_r;
            case (cmd_op_r)
              CMD_RECEIVE: begin
                // start of a list: fetched when data first arrives [RULE1] [RULE7]
                db_addr[cmd_ch_r]   <= branch_r;
                db_loaded[cmd_ch_r] <= 1'b0;
                db_held[cmd_ch_r]   <= 1'b0;
                db_newpkt[cmd_ch_r] <= 1'b1;
                db_mid[cmd_ch_r]    <= 1'b0;
              end
              CMD_HOLD_RESET: begin
                // parked channel polls its last descriptor again [RULE10]
                if (db_held[cmd_ch_r] && db_loaded[cmd_ch_r]) begin
                  db_held[cmd_ch_r] <= 1'b0;
                  state_r <= S_REPOLL;
                  widx_r  <= 2'h0;
                  mem_req <= '{we: 1'b0, addr: db_addr[cmd_ch_r], wdata: 32'h0, be: 4'h0};
                end
              end
              CMD_ABORT: begin
                if (db_loaded[cmd_ch_r] && db_mid[cmd_ch_r]) begin
                  // frame cut short: close with complete, end and abort flag
                  abort_r <= 1'b1;
                  state_r <= S_STATUS;
                  mem_req <= '{we: 1'b1, addr: db_addr[cmd_ch_r] + DW_STAT,
                               wdata: {1'b1, 1'b1, 9'h0, 5'h1 << ERR_ABORT,
                                       db_cnt[cmd_ch_r][15:0]}, be: 4'hf};
                end else begin
                  db_addr[cmd_ch_r]   <= branch_r;          // [RULE20]
                  db_loaded[cmd_ch_r] <= 1'b0;
                  db_held[cmd_ch_r]   <= 1'b0;
                  db_newpkt[cmd_ch_r] <= 1'b1;
                  db_mid[cmd_ch_r]    <= 1'b0;
                end
              end
              default: ;                     // no operation
            endcase
          end else if (rx_valid && !db_held[rch] && !db_loaded[rch]) begin
            // descriptor not cached: read its three host words [RULE7]
            ch_r    <= rch;
            state_r <= S_FETCH;
            widx_r  <= 2'h0;
            mem_req <= '{we: 1'b0, addr: db_addr[rch], wdata: 32'h0, be: 4'h0};
          end else if (rx_ready) begin
            ch_r <= rch;
            if (rx_beat.last) begin
              // frame status goes only to the status word [RULE18] [RULE22] [RULE23]
              state_r <= S_STATUS;
              mem_req <= '{we: 1'b1, addr: db_addr[rch] + DW_STAT,  // [RULE2] [RULE8]
                           wdata: {1'b1, 1'b1, 9'h0, rx_beat.data[ERR_W-1:0],
                                   db_cnt[rch][15:0]}, be: 4'hf};
            end else begin
              // payload word lands after offset and earlier bytes [RULE13] [RULE17]
              bcnt_r  <= 17'(rx_beat.nbytes);
              state_r <= S_DATA;
              mem_req <= '{we: 1'b1,
                           addr: db_dptr[rch] + 32'(db_start[rch]) + 32'(db_cnt[rch]),
                           wdata: order(rx_beat.data, big),
                           be: lanes(rx_beat.nbytes, big)};
            end
          end
        end
        S_FETCH: begin
          if (mem_ack) begin
            case (widx_r)
              2'h0: db_w0[ch_r] <= mem_rdata;
              2'h1: db_next[ch_r] <= mem_rdata & PTR_MASK;
              default: db_dptr[ch_r] <= mem_rdata & PTR_MASK;
            endcase
            widx_r <= widx_r + 2'h1;
            mem_req.addr <= mem_req.addr + DW_NEXT;
            if (widx_r == 2'h0) begin
              // header offset only on the first descriptor of a packet [RULE13]
              db_start[ch_r] <= (db_newpkt[ch_r] && !ctrl_r[CTRL_TRN_BIT])
                                ? {mem_rdata[W0_OFS_HI:W0_OFS_LO], 2'h0} : 5'h0;
            end
            if (widx_r == 2'h2) begin
              db_loaded[ch_r] <= 1'b1;
              db_cnt[ch_r]    <= 17'h0;
              state_r         <= S_IDLE;
            end
          end
        end
        S_DATA: begin
          if (mem_ack) begin
            db_cnt[ch_r] <= 17'(fill_nxt - 18'(db_start[ch_r]));
            db_mid[ch_r] <= 1'b1;
            if (fill_nxt >= 18'(db_w0[ch_r][W0_SIZE_HI:0])) begin
              // section full: complete with byte count [RULE3] [RULE21] [RULE23]
              mem_req <= '{we: 1'b1, addr: db_addr[ch_r] + DW_STAT,
                           wdata: {1'b0, 1'b1, 14'h0,
                                   16'(fill_nxt - 18'(db_start[ch_r]))}, be: 4'hf};
              state_r <= S_STATUS;
            end else begin
              state_r <= S_IDLE;
            end
          end
        end
        S_STATUS: begin
          if (mem_ack) begin
            // vectors follow the status write, tag attached [RULE12] [RULE15] [RULE22]
            vec.chan      <= ch_r;
            vec.tag       <= db_w0[ch_r][W0_TAG_HI:W0_TAG_LO];
            vec.frame_end <= mem_req.wdata[ST_FE_BIT] && ctrl_r[CTRL_FEV_BIT];
            vec.host_irq  <= db_w0[ch_r][W0_RHI];
            vec_valid     <= (mem_req.wdata[ST_FE_BIT] && ctrl_r[CTRL_FEV_BIT])
                             || db_w0[ch_r][W0_RHI];
            db_newpkt[ch_r] <= mem_req.wdata[ST_FE_BIT];  // [RULE4]
            if (mem_req.wdata[ST_FE_BIT]) begin
              db_mid[ch_r] <= 1'b0;
            end
            abort_r <= 1'b0;
            if (abort_r) begin
              db_addr[ch_r]   <= branch_r;   // [RULE20]
              db_loaded[ch_r] <= 1'b0;
              db_held[ch_r]   <= 1'b0;
              db_newpkt[ch_r] <= 1'b1;
              state_r         <= S_IDLE;
            end else if (!db_w0[ch_r][W0_HOLD]) begin
              db_addr[ch_r]   <= db_next[ch_r];  // [RULE9]
              db_loaded[ch_r] <= 1'b0;
              state_r         <= S_IDLE;
            end else begin
              // last of list: poll word 0 once more [RULE10]
              state_r <= S_REPOLL;
              widx_r  <= 2'h0;
              mem_req <= '{we: 1'b0, addr: db_addr[ch_r], wdata: 32'h0, be: 4'h0};
            end
          end
        end
        S_REPOLL: begin
          if (mem_ack) begin
            if (widx_r == 2'h0) begin
              // only hold and next pointer are refreshed [RULE11]
              db_w0[ch_r][W0_HOLD] <= mem_rdata[W0_HOLD];
              hold_seen_r  <= mem_rdata[W0_HOLD];
              widx_r       <= 2'h1;
              mem_req.addr <= mem_req.addr + DW_NEXT;
            end else begin
              db_next[ch_r] <= mem_rdata & PTR_MASK;
              state_r       <= S_IDLE;
              if (hold_seen_r) begin
                db_held[ch_r] <= 1'b1;       // parked until a command [RULE10]
              end else begin
                db_addr[ch_r]   <= mem_rdata & PTR_MASK;  // [RULE9]
                db_loaded[ch_r] <= 1'b0;
              end
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### rdl_rx_dma_checker.sv
/*
  port assertions for the receive descriptor dma engine.
  assumes a bind onto rdl_rx_dma and a memory that acks each request once.
*/
`timescale 1ns/1ps
`default_nettype none
module rdl_rx_dma_checker import rdl_pkg::*; (
  input wire logic         clk,       // system clock
  input wire logic         rst,       // sync reset, active high
  input wire rdl_rx_beat_t rx_beat,   // receive beat
  input wire logic         rx_valid,  // beat offered
  input wire logic         rx_ready,  // beat taken
  input wire rdl_mem_req_t mem_req,   // memory request
  input wire logic         mem_valid, // request pending
  input wire logic         mem_ack,   // memory done
  input wire rdl_vec_t     vec,       // interrupt vector
  input wire logic         vec_valid  // vector pulse
);
  wire logic       take   = rx_valid && rx_ready;  // beat handed over
  wire logic       st_ack = mem_valid && mem_ack && mem_req.we && mem_req.be == 4'hf;
  logic      [4:0] err_r;                          // frame status of last taken end beat

  // error bits of the last end beat
  always_ff @(posedge clk) begin
    if (take && rx_beat.last) begin
      err_r <= rx_beat.data[4:0];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_req_holds: assert property (mem_valid && !mem_ack |=> $stable(mem_req))
    else $error("memory request moved before ack");
  a_addr_word: assert property (mem_valid |-> mem_req.addr[1:0] == 2'h0)
    else $error("memory address not word aligned");
  a_ready_idle: assert property (rx_ready |-> !mem_valid)
    else $error("beat taken while memory busy");
  a_beat_write: assert property (take && !rx_beat.last && rx_beat.nbytes == 3'h4
    |-> ##[1:2] mem_valid && mem_req.we && mem_req.be == 4'hf)
    else $error("full beat not written as a word");
  // end beat never reaches the section, only the status word
  a_frame_status: assert property (take && rx_beat.last |-> ##[1:2] mem_valid && mem_req.we
    && mem_req.wdata[31:21] == {2'b11, 9'h0} && mem_req.wdata[20:16] == err_r)
    else $error("frame end status word wrong");
  a_vec_pulse: assert property (vec_valid |=> !vec_valid)
    else $error("vector longer than one cycle");
  a_vec_after_st: assert property (vec_valid |-> $past(st_ack))
    else $error("vector without a status write");
  a_vec_cause: assert property (vec_valid |-> vec.frame_end || vec.host_irq)
    else $error("vector with no cause");

  c_end_beat: cover property (take && rx_beat.last);
  c_host_vec: cover property (vec_valid && vec.host_irq);
  c_fe_vec: cover property (vec_valid && vec.frame_end && !vec.host_irq);
endmodule
`default_nettype wire

// ### tb_rx_descriptor_dma_list.sv
/*
  testbench: apb and beat tasks walk one channel through a descriptor list.
  assumes rdl_pkg, the engine, the memory model and the checker come first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, g) begin check_count++; if ((g) !== (x)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, x, g); end end
module tb_rx_descriptor_dma_list import rdl_pkg::*;;
  logic         clk, rst, psel, penable, pwrite, rx_valid; // driven here
  logic   [7:0] paddr; // apb address
  logic  [31:0] pwdata, prdata, mem_rdata, q; // q: last apb read
  logic         pready, pslverr, rx_ready, mem_valid, mem_ack, vec_valid, e;
  logic   [3:0] lat; // memory wait
  rdl_rx_beat_t rx_beat; // beat offered
  rdl_mem_req_t mem_req; // engine request
  rdl_vec_t     vec; // vector out
  rdl_vec_t     vq[$]; // vectors seen
  logic  [15:0] ev [4] = '{16'h056a, 16'h0595, 16'h05c7, 16'h0581}; // expected
  int           err_total, check_count, cyc;

  rdl_rx_dma i_rdl_rx_dma (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_beat(rx_beat), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .mem_req(mem_req), .mem_valid(mem_valid), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .vec(vec), .vec_valid(vec_valid));
  rdl_mem_model i_rdl_mem_model (.clk(clk), .rst(rst), .lat(lat), .mem_req(mem_req),
    .mem_valid(mem_valid), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // collect vectors; a hang ends the run
  always @(posedge clk) begin
    if (vec_valid === 1'b1) vq.push_back(vec);
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // one apb transfer; idle cycle after so calls never collide
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // commands are dropped while one is pending
  task automatic cmd(input logic [31:0] c);
    apb(1'b1, OFF_CMD, c);
    do apb(1'b0, OFF_CMD, 32'h0); while (q[CMD_PEND_BIT] !== 1'b0);
  endtask

  task automatic offer(input logic [31:0] d, input logic [2:0] n, input logic l);
    rx_beat  <= {8'h05, d, n, l};
    rx_valid <= 1'b1;
  endtask

  task automatic take();
    @(posedge clk);
    while (rx_ready !== 1'b1) @(posedge clk);
    rx_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic beat(input logic [31:0] d, input logic [2:0] n, input logic l);
    offer(d, n, l);
    take();
  endtask

  // engine quiet for eight cycles
  task automatic settle();
    int n = 0;
    while (n < 8) begin
      @(posedge clk);
      n = (mem_valid === 1'b0) ? n + 1 : 0;
    end
  endtask

  function automatic logic [31:0] w0(input logic h, r, input logic [2:0] o,
                                     input logic [5:0] t, input logic [15:0] s);
    return {1'b0, h, r, o, 4'h0, t, s};
  endfunction

  task automatic desc(input logic [10:0] a, input logic [31:0] x, n, p);
    i_rdl_mem_model.mem[a[10:2]]        = x;
    i_rdl_mem_model.mem[a[10:2] + 9'h1] = n;
    i_rdl_mem_model.mem[a[10:2] + 9'h2] = p;
  endtask

  function automatic logic [31:0] rd(input logic [10:0] a);
    return i_rdl_mem_model.mem[a[10:2]];
  endfunction

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, rx_valid} = 4'h0;
    {paddr, pwdata} = '0;
    rx_beat = '0;
    lat = 4'h2;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // aligned pointers, byte sizes in whole words, offset inside size
    desc(11'h100, w0(1'b0, 1'b1, 3'h0, 6'h2a, 16'h8), 32'h110, 32'h200);
    desc(11'h110, w0(1'b1, 1'b0, 3'h1, 6'h15, 16'h10), 32'h120, 32'h300);
    desc(11'h140, w0(1'b1, 1'b1, 3'h2, 6'h07, 16'h10), 32'h0, 32'h400);
    desc(11'h180, w0(1'b1, 1'b0, 3'h1, 6'h01, 16'h8), 32'h0, 32'h500);
    apb(1'b0, OFF_CTRL, 32'h0);
    `CHK("ctrl", {29'h0, CTRL_RST}, q)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", {1'b1, 32'h0}, {e, q})
    apb(1'b1, OFF_BRANCH, 32'h103);
    apb(1'b0, OFF_BRANCH, 32'h0);
    `CHK("branch", 32'h100, q)
    cmd(32'h105);
    beat(32'h44332211, 3'h4, 1'b0);
    beat(32'h88776655, 3'h4, 1'b0);
    settle();
    beat(32'hccbbaa99, 3'h2, 1'b0);
    beat(32'h00000004, 3'h0, 1'b1);
    settle();
    `CHK("d0", 32'h44332211, rd(11'h200))
    `CHK("d1", 32'h88776655, rd(11'h204))
    `CHK("st_a", 32'h40000008, rd(11'h10c))
    `CHK("d2", 32'hffffaa99, rd(11'h300))
    `CHK("d3", 32'hffffffff, rd(11'h304))
    `CHK("st_b", 32'hc0040002, rd(11'h11c))
    // held descriptor: the channel parks and the beat waits
    offer(32'h11111111, 3'h4, 1'b0);
    repeat (10) @(posedge clk);
    `CHK("parked", 1'b0, rx_ready)
    desc(11'h110, w0(1'b0, 1'b1, 3'h0, 6'h3f, 16'h4), 32'h140, 32'h300);
    cmd(32'h205);
    take();
    beat(32'h0, 3'h0, 1'b1);
    settle();
    `CHK("d4", 32'h11111111, rd(11'h408))
    `CHK("d5", 32'hffffffff, rd(11'h400))
    `CHK("st_c", 32'hc0000004, rd(11'h14c))
    // slow memory, big endian, transparent, abort mid-frame
    lat <= 4'h6;
    apb(1'b1, OFF_CTRL, 32'h7);
    apb(1'b1, OFF_BRANCH, 32'h180);
    cmd(32'h305);
    beat(32'ha1b2c3d4, 3'h4, 1'b0);
    cmd(32'h305);
    settle();
    `CHK("d6", 32'hd4c3b2a1, rd(11'h500))
    `CHK("st_d", 32'hc0010004, rd(11'h18c))
    `CHK("vec_n", 4, vq.size())
    foreach (ev[i]) if (i < vq.size()) `CHK("vec", ev[i], vq[i])
    print_verdict();
  end
endmodule
bind rdl_rx_dma rdl_rx_dma_checker i_rdl_rx_dma_checker (.clk(clk), .rst(rst),
  .rx_beat(rx_beat), .rx_valid(rx_valid), .rx_ready(rx_ready), .mem_req(mem_req),
  .mem_valid(mem_valid), .mem_ack(mem_ack), .vec(vec), .vec_valid(vec_valid));
`default_nettype wire
